// File: common/bwsc_pkg.sv
// Constants for the bandwidth stride and window configuration bank.
// Assumes one 100 MHz clock and a simple one-cycle register access port.
//
// Contract
// - Stride setting stored per selected partition
// - Stride register only with both capabilities
// - Enable bit 31 gates stride regulation
// - Stride field holds cost, stride minus one
// - Only allocation-width stride bits implemented
// - Separate secure and non-secure copies
// - Instance selector indexes when present
// - Window register only with bandwidth partitioning
// - Window read-only, hardware width when unwritable
// - Window writable per partition when flagged
// - Window integer microseconds in bits 23:8
// - Window fraction microseconds in bits 7:0
// - Selector low sixteen bits pick partition
// - Selector bits 27:24 pick resource instance
// - Wrong internal bit flags error, blocks write
`default_nettype none

package bwsc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_WINDOW    = 12'h220; // Window width page offset
  localparam logic [11:0] OFF_STRIDE    = 12'h500; // Stride page offset
  localparam int          ADDR_W        = 12;      // Page offset width
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          STRIDE_EN_BIT = 31;      // Stride enable
  localparam int          STRIDE_W      = 16;      // Stride field width
  localparam int          BW_ALLOC_WIDTH        = 8;       // Implemented stride bits
  localparam int          WIN_W         = 24;      // Integer plus fraction
  localparam int          WIN_FRAC_W    = 8;       // Fraction bits 7:0
  localparam int          SEL_PART_W    = 16;      // Selector partition field
  localparam int          SEL_INT_BIT   = 16;      // Selector internal bit
  localparam int          SEL_RIS_LSB   = 24;      // Selector instance field
  localparam int          SEL_RIS_W     = 4;       // Instance field width
  // ----------------------------------------------------------------
  // Storage shape and reset values
  // ----------------------------------------------------------------
  localparam int          PART_W        = 3;       // Stored partitions: 8
  localparam int          IDX_W         = PART_W + 2; // Security, instance, part
  localparam int          ENTRIES       = 1 << IDX_W;
  localparam logic        EN_RST        = 1'b0;
  localparam logic [BW_ALLOC_WIDTH-1:0] STRIDE_RST = 8'h00;
  localparam logic [WIN_W-1:0]  WIN_RST    = 24'h000000;
endpackage

`default_nettype wire

// File: hw/bwsc_store.sv
// Per-partition storage array for stride and window settings.
// Assumes writes are already decoded and qualified by the bank top.
`default_nettype none

module bwsc_store (
  input  wire logic                        clk_sys_in,   // System clock
  input  wire logic                        rstn_in,      // Sync reset, low
  input  wire logic                        wr_stride_in, // Write stride entry
  input  wire logic                        wr_win_in,    // Write window entry
  input  wire logic [bwsc_pkg::IDX_W-1:0]  widx_in,      // Write index
  input  wire logic                        wen_bit_in,   // Enable to store
  input  wire logic [bwsc_pkg::BW_ALLOC_WIDTH-1:0] wstride_in,   // Stride to store
  input  wire logic [bwsc_pkg::WIN_W-1:0]  wwin_in,      // Window to store
  input  wire logic [bwsc_pkg::IDX_W-1:0]  ridx_a_in,    // Bus read index
  output logic                             en_a_out,     // Bus read enable
  output logic      [bwsc_pkg::BW_ALLOC_WIDTH-1:0] stride_a_out, // Bus read stride
  output logic      [bwsc_pkg::WIN_W-1:0]  win_a_out,    // Bus read window
  input  wire logic [bwsc_pkg::IDX_W-1:0]  ridx_b_in,    // Regulator index
  output logic                             en_b_out,     // Regulator enable
  output logic      [bwsc_pkg::BW_ALLOC_WIDTH-1:0] stride_b_out, // Regulator stride
  output logic      [bwsc_pkg::WIN_W-1:0]  win_b_out     // Regulator window
);
  // ----------------------------------------------------------------
  // Arrays, one entry per security state, instance and partition
  // ----------------------------------------------------------------
  logic                        en_q     [bwsc_pkg::ENTRIES]; // Enable bits
  logic [bwsc_pkg::BW_ALLOC_WIDTH-1:0] stride_q [bwsc_pkg::ENTRIES]; // Stride costs
  logic [bwsc_pkg::WIN_W-1:0]  win_q    [bwsc_pkg::ENTRIES]; // Window widths

  // Storage update; reset clears every entry so regulation starts off
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < bwsc_pkg::ENTRIES; i++) begin
        en_q[i]     <= bwsc_pkg::EN_RST;
        stride_q[i] <= bwsc_pkg::STRIDE_RST;
        win_q[i]    <= bwsc_pkg::WIN_RST;
      end
    end else begin
      if (wr_stride_in) begin
        en_q[widx_in]     <= wen_bit_in;
        stride_q[widx_in] <= wstride_in;
      end
      if (wr_win_in) begin
        win_q[widx_in] <= wwin_in;
      end
    end
  end

  // Two independent read ports
  assign en_a_out     = en_q[ridx_a_in];
  assign stride_a_out = stride_q[ridx_a_in];
  assign win_a_out    = win_q[ridx_a_in];
  assign en_b_out     = en_q[ridx_b_in];
  assign stride_b_out = stride_q[ridx_b_in];
  assign win_b_out    = win_q[ridx_b_in];
endmodule

`default_nettype wire

// File: hw/bwsc_bank.sv
// Stride and window-width configuration bank with secure and non-secure pages.
// Assumes the partition selectors live elsewhere and arrive as plain inputs,
// and that capability flags are static configuration on the same clock.
`default_nettype none

module bwsc_bank (
  input  wire logic                        clk_sys_in,        // 100 MHz clock
  input  wire logic                        rstn_in,           // Sync reset, low
  input  wire logic                        acc_req_in,        // Access request
  input  wire logic                        acc_wr_in,         // 1 write, 0 read
  input  wire logic                        acc_secure_in,     // 1 secure page
  input  wire logic [bwsc_pkg::ADDR_W-1:0] acc_addr_in,       // Page offset
  input  wire logic [31:0]                 acc_wdata_in,      // Write data
  output logic                             acc_ack_out,       // Access done
  output logic      [31:0]                 acc_rdata_out,     // Read data
  output logic                             acc_err_out,       // Internal bit error
  input  wire logic [31:0]                 part_sel_s_in,     // Secure selector
  input  wire logic [31:0]                 part_sel_ns_in,    // Non-secure selector
  input  wire logic                        bw_partitioning_present_in, // Capability
  input  wire logic                        stride_support_present_in,  // Capability
  input  wire logic                        instance_select_present_in, // Capability
  input  wire logic                        narrowing_present_in,       // Capability
  input  wire logic                        window_writable_flag_in,    // Capability
  input  wire logic [bwsc_pkg::WIN_W-1:0]  hw_window_in,      // Hardware window
  input  wire logic                        reg_secure_in,     // Regulator query
  input  wire logic [15:0]                 reg_part_in,       // Regulator partition
  input  wire logic [3:0]                  reg_ris_in,        // Regulator instance
  output logic                             reg_stride_en_out, // Stride regulation on
  output logic      [15:0]                 reg_stride_out,    // Stride minus one
  output logic      [bwsc_pkg::WIN_W-1:0]  reg_window_out     // Window width
);
  // ----------------------------------------------------------------
  // Index decoding, shared by bus and regulator paths
  // ----------------------------------------------------------------
  // Returns {in_range, security, instance, partition}. Partitions beyond the
  // stored range read zero and drop writes rather than alias.
  function automatic logic [bwsc_pkg::IDX_W:0] cfg_index(
    input logic        sec,
    input logic [31:0] sel,
    input logic        ris_on
  );
    logic ok;
    logic resource_instance_selector;
    ok  = (sel[bwsc_pkg::SEL_PART_W-1:bwsc_pkg::PART_W] == '0) &&
          (!ris_on || sel[bwsc_pkg::SEL_RIS_LSB+bwsc_pkg::SEL_RIS_W-1:
                          bwsc_pkg::SEL_RIS_LSB+1] == '0);
    resource_instance_selector = ris_on & sel[bwsc_pkg::SEL_RIS_LSB];
    return {ok, sec, resource_instance_selector, sel[bwsc_pkg::PART_W-1:0]};
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [31:0]                 sel_w;       // Selector of the accessing page
  logic [bwsc_pkg::IDX_W:0]    bus_ix_w;    // Decoded bus index
  logic                        in_range_w;  // Index is stored
  logic                        hit_stride_w; // Stride register present and hit
  logic                        hit_win_w;   // Window register present and hit
  logic                        int_bad_w;   // Internal bit wrong for access
  logic                        err_w;       // Flag an internal-bit error
  logic                        wr_stride_w; // Qualified stride write
  logic                        wr_win_w;    // Qualified window write
  logic                        en_a_w;      // Stored enable, bus port
  logic [bwsc_pkg::BW_ALLOC_WIDTH-1:0] stride_a_w;  // Stored stride, bus port
  logic [bwsc_pkg::WIN_W-1:0]  win_a_w;     // Stored window, bus port
  logic [bwsc_pkg::WIN_W-1:0]  win_rd_w;    // Window value seen by software
  logic [31:0]                 rd_w;        // Read data before register

  assign sel_w      = acc_secure_in ? part_sel_s_in : part_sel_ns_in;
  assign bus_ix_w   = cfg_index(acc_secure_in, sel_w, instance_select_present_in);
  assign in_range_w = bus_ix_w[bwsc_pkg::IDX_W];
  assign hit_stride_w = (acc_addr_in == bwsc_pkg::OFF_STRIDE) &&
                        bw_partitioning_present_in && stride_support_present_in;
  assign hit_win_w  = (acc_addr_in == bwsc_pkg::OFF_WINDOW) &&
                      bw_partitioning_present_in;
  // Without narrowing the internal bit is forced to zero by the selector, so
  // only the narrowing case can be wrong; software must set it first.
  assign int_bad_w  = narrowing_present_in && !sel_w[bwsc_pkg::SEL_INT_BIT];
  assign err_w      = acc_req_in && (hit_stride_w || hit_win_w) && int_bad_w;
  assign wr_stride_w = acc_req_in && acc_wr_in && hit_stride_w &&
                       !int_bad_w && in_range_w;
  assign wr_win_w   = acc_req_in && acc_wr_in && hit_win_w && !int_bad_w &&
                      in_range_w && window_writable_flag_in;

  // A read-only window reports the hardware width, which may change anytime
  assign win_rd_w = window_writable_flag_in ? win_a_w : hw_window_in;

  // Read mux; errored, absent and out-of-range reads return zero
  assign rd_w = (int_bad_w || !in_range_w) ? 32'h0000_0000 :
                hit_stride_w ? {en_a_w, 15'h0000,
                                {(bwsc_pkg::STRIDE_W-bwsc_pkg::BW_ALLOC_WIDTH){1'b0}},
                                stride_a_w} :
                hit_win_w    ? {8'h00, win_rd_w} :
                32'h0000_0000;

  // ----------------------------------------------------------------
  // Regulator query decode
  // ----------------------------------------------------------------
  logic [bwsc_pkg::IDX_W:0]    reg_ix_w;    // Decoded regulator index
  logic                        en_b_w;      // Stored enable, regulator port
  logic [bwsc_pkg::BW_ALLOC_WIDTH-1:0] stride_b_w;  // Stored stride, regulator port
  logic [bwsc_pkg::WIN_W-1:0]  win_b_w;     // Stored window, regulator port

  assign reg_ix_w = cfg_index(reg_secure_in, {4'h0, reg_ris_in, 8'h00, reg_part_in},
                              instance_select_present_in);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  bwsc_store u_store (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .wr_stride_in (wr_stride_w),
    .wr_win_in    (wr_win_w),
    .widx_in      (bus_ix_w[bwsc_pkg::IDX_W-1:0]),
    .wen_bit_in   (acc_wdata_in[bwsc_pkg::STRIDE_EN_BIT]),
    .wstride_in   (acc_wdata_in[bwsc_pkg::BW_ALLOC_WIDTH-1:0]),
    .wwin_in      (acc_wdata_in[bwsc_pkg::WIN_W-1:0]),
    .ridx_a_in    (bus_ix_w[bwsc_pkg::IDX_W-1:0]),
    .en_a_out     (en_a_w),
    .stride_a_out (stride_a_w),
    .win_a_out    (win_a_w),
    .ridx_b_in    (reg_ix_w[bwsc_pkg::IDX_W-1:0]),
    .en_b_out     (en_b_w),
    .stride_b_out (stride_b_w),
    .win_b_out    (win_b_w)
  );

  // ----------------------------------------------------------------
  // Registered bus answer
  // ----------------------------------------------------------------
  // Every access answers one cycle later; writes return zero data
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      acc_ack_out   <= 1'b0;
      acc_rdata_out <= 32'h0000_0000;
      acc_err_out   <= 1'b0;
    end else begin
      acc_ack_out   <= acc_req_in;
      acc_rdata_out <= (acc_req_in && !acc_wr_in) ? rd_w : 32'h0000_0000;
      acc_err_out   <= err_w;
    end
  end

  // ----------------------------------------------------------------
  // Registered settings toward the regulator datapath
  // ----------------------------------------------------------------
  // Disabled or unknown partitions present enable low, so the regulator
  // leaves them alone; a larger stride means a larger cost per access.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      reg_stride_en_out <= bwsc_pkg::EN_RST;
      reg_stride_out    <= 16'h0000;
      reg_window_out    <= bwsc_pkg::WIN_RST;
    end else begin
      reg_stride_en_out <= reg_ix_w[bwsc_pkg::IDX_W] && en_b_w &&
                           bw_partitioning_present_in && stride_support_present_in;
      reg_stride_out    <= {{(bwsc_pkg::STRIDE_W-bwsc_pkg::BW_ALLOC_WIDTH){1'b0}},
                            stride_b_w};
      reg_window_out    <= window_writable_flag_in ? win_b_w : hw_window_in;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  a_ack_timing: assert property (acc_req_in |=> acc_ack_out ##1
      (!acc_ack_out || $past(acc_req_in)))
    else $error("access not answered one cycle later");
  a_stride_absent: assert property (acc_req_in && !acc_wr_in &&
      acc_addr_in == bwsc_pkg::OFF_STRIDE && !(bw_partitioning_present_in &&
      stride_support_present_in) |=> acc_rdata_out == 32'h0000_0000)
    else $error("absent stride register read nonzero");
  a_window_absent: assert property (acc_req_in && !acc_wr_in &&
      acc_addr_in == bwsc_pkg::OFF_WINDOW && !bw_partitioning_present_in
      |=> acc_rdata_out == 32'h0000_0000)
    else $error("absent window register read nonzero");
  a_stride_reserved: assert property (acc_req_in && !acc_wr_in &&
      acc_addr_in == bwsc_pkg::OFF_STRIDE |=> acc_rdata_out[30:bwsc_pkg::BW_ALLOC_WIDTH] == '0)
    else $error("stride reserved bits read nonzero");
  a_window_reserved: assert property (acc_req_in && !acc_wr_in &&
      acc_addr_in == bwsc_pkg::OFF_WINDOW |=> acc_rdata_out[31:bwsc_pkg::WIN_W] == '0)
    else $error("window reserved bits read nonzero");
  a_window_readonly: assert property (acc_req_in && !acc_wr_in && hit_win_w &&
      !int_bad_w && in_range_w && !window_writable_flag_in
      |=> acc_rdata_out == {8'h00, $past(hw_window_in)})
    else $error("read-only window not hardware width");
  // Looks at the entry itself, so a wrong index or a lost write shows up
  a_window_written: assert property (acc_req_in && acc_wr_in && hit_win_w &&
      !int_bad_w && in_range_w && window_writable_flag_in
      |=> u_store.win_q[$past(bus_ix_w[bwsc_pkg::IDX_W-1:0])] ==
          $past(acc_wdata_in[bwsc_pkg::WIN_W-1:0]))
    else $error("writable window write dropped");
  a_stride_stored: assert property (wr_stride_w |=>
      u_store.stride_q[$past(bus_ix_w[bwsc_pkg::IDX_W-1:0])] ==
      $past(acc_wdata_in[bwsc_pkg::BW_ALLOC_WIDTH-1:0]))
    else $error("stride write not stored");
  a_internal_error: assert property (err_w |-> !wr_stride_w && !wr_win_w
      ##1 acc_err_out && acc_rdata_out == 32'h0000_0000)
    else $error("internal bit error not flagged or write leaked");
  a_security_split: assert property (wr_stride_w || wr_win_w
      |-> bus_ix_w[bwsc_pkg::IDX_W-1] == acc_secure_in)
    else $error("write reached wrong security copy");
  a_instance_index: assert property (!instance_select_present_in
      |-> bus_ix_w[bwsc_pkg::PART_W] == 1'b0 && reg_ix_w[bwsc_pkg::PART_W] == 1'b0)
    else $error("instance bit used without instance selection");
  a_stride_disabled: assert property (!(bw_partitioning_present_in &&
      stride_support_present_in) |=> !reg_stride_en_out)
    else $error("stride regulation enabled without support");
  a_stride_high_zero: assert property (
      reg_stride_out[bwsc_pkg::STRIDE_W-1:bwsc_pkg::BW_ALLOC_WIDTH] == '0)
    else $error("unimplemented stride bits reach regulator");
  a_enable_range: assert property (reg_stride_en_out |->
      $past(reg_ix_w[bwsc_pkg::IDX_W]) && $past(en_b_w))
    else $error("regulation enabled for unstored partition");

  c_stride_write: cover property (wr_stride_w ##1 acc_ack_out);
  c_window_write: cover property (wr_win_w);
  c_error_flag:   cover property (acc_err_out);
  c_regulated:    cover property (reg_stride_en_out);
endmodule

`default_nettype wire

// File: tb/bwsc_bank_tb.sv
// Self-checking bench for the stride and window configuration bank.
// Assumes the one-cycle access answer and the one-cycle query answer of the bank.
`default_nettype none

module bwsc_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Design signals
  // ----------------------------------------------------------------
  logic        clk_sys_in, rstn_in, acc_req_in, acc_wr_in, acc_secure_in;
  logic [11:0] acc_addr_in;
  logic [31:0] acc_wdata_in, acc_rdata_out, part_sel_s_in, part_sel_ns_in;
  logic        acc_ack_out, acc_err_out, bwp_in, ssp_in, isp_in, nrw_in, wwf_in;
  logic [23:0] hw_window_in, reg_window_out;
  logic        reg_secure_in, reg_stride_en_out;
  logic [15:0] reg_part_in, reg_stride_out;
  logic [3:0]  reg_ris_in;
  // Model state: one entry per security, instance, partition
  int          en_m[64], st_m[64], win_m[64];
  int          fails, check_count, seed, p;
  logic        s, r;
  logic [11:0] addrs[3];

  bwsc_bank u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .acc_req_in(acc_req_in),
    .acc_wr_in(acc_wr_in), .acc_secure_in(acc_secure_in), .acc_addr_in(acc_addr_in),
    .acc_wdata_in(acc_wdata_in), .acc_ack_out(acc_ack_out), .acc_rdata_out(acc_rdata_out),
    .acc_err_out(acc_err_out), .part_sel_s_in(part_sel_s_in), .part_sel_ns_in(part_sel_ns_in),
    .bw_partitioning_present_in(bwp_in), .stride_support_present_in(ssp_in),
    .instance_select_present_in(isp_in), .narrowing_present_in(nrw_in),
    .window_writable_flag_in(wwf_in), .hw_window_in(hw_window_in),
    .reg_secure_in(reg_secure_in), .reg_part_in(reg_part_in), .reg_ris_in(reg_ris_in),
    .reg_stride_en_out(reg_stride_en_out), .reg_stride_out(reg_stride_out),
    .reg_window_out(reg_window_out));

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Selector word: instance in 27:24, internal bit 16, partition 15:0
  task automatic setsel(input logic sec, input logic [3:0] resource_instance_selector, input int part, input logic ib);
    if (sec) part_sel_s_in = {4'h0, resource_instance_selector, 7'h00, ib, part[15:0]};
    else part_sel_ns_in = {4'h0, resource_instance_selector, 7'h00, ib, part[15:0]};
  endtask

  // One access; the model decides rdata and the error pulse
  task automatic acc(input logic wr, input logic sec, input logic [11:0] addr,
                     input logic [31:0] d);
    logic [31:0] sel, exp_d;
    logic        exp_e, ok, hit_s, hit_w;
    int          idx;
    sel   = sec ? part_sel_s_in : part_sel_ns_in;
    hit_s = (addr == bwsc_pkg::OFF_STRIDE) && bwp_in && ssp_in;
    hit_w = (addr == bwsc_pkg::OFF_WINDOW) && bwp_in;
    exp_e = nrw_in && !sel[16] && (hit_s || hit_w);
    ok    = !exp_e && (sel[15:0] < 16'h0008) && !(isp_in && sel[27:25] != 3'h0);
    idx   = {sec, isp_in & sel[24], sel[2:0]};
    exp_d = 32'h00000000;
    if (hit_s && ok) begin
      if (wr) begin
        en_m[idx] = d[31];
        st_m[idx] = d[7:0];
      end else exp_d = {en_m[idx][0], 15'h0000, 8'h00, st_m[idx][7:0]};
    end
    if (hit_w && ok && !wwf_in && !wr) exp_d = {8'h00, hw_window_in};
    if (hit_w && ok && wwf_in) begin
      if (wr) win_m[idx] = d[23:0];
      else exp_d = {8'h00, win_m[idx][23:0]};
    end
    @(posedge clk_sys_in) #1;
    {acc_req_in, acc_wr_in, acc_secure_in, acc_addr_in, acc_wdata_in} = {1'b1, wr, sec, addr, d};
    @(posedge clk_sys_in) #1;
    acc_req_in = 1'b0;
    chk({31'h0, acc_ack_out}, 32'h1);
    chk({31'h0, acc_err_out}, {31'h0, exp_e});
    chk(acc_rdata_out, exp_d);
  endtask

  // Regulator query of an in-range partition
  task automatic rq(input logic sec, input int part, input logic resource_instance_selector);
    int idx;
    idx = {sec, resource_instance_selector, part[2:0]};
    {reg_secure_in, reg_part_in, reg_ris_in} = {sec, part[15:0], 3'h0, resource_instance_selector};
    @(posedge clk_sys_in) #1;
    chk({31'h0, reg_stride_en_out}, {31'h0, en_m[idx][0]});
    chk({16'h0, reg_stride_out}, {24'h0, st_m[idx][7:0]});
    chk({8'h0, reg_window_out}, {8'h0, wwf_in ? win_m[idx][23:0] : hw_window_in});
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #400000;
    fails++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {acc_req_in, acc_wr_in, acc_secure_in, acc_addr_in, acc_wdata_in} = '0;
    {part_sel_s_in, part_sel_ns_in, hw_window_in, reg_secure_in, reg_part_in, reg_ris_in} = '0;
    {bwp_in, ssp_in, isp_in, nrw_in, wwf_in} = 5'h1d;
    fails = 0; check_count = 0; seed = 38;
    addrs = '{bwsc_pkg::OFF_STRIDE, bwsc_pkg::OFF_WINDOW, 12'h104};
    for (int i = 0; i < 64; i++) {en_m[i], st_m[i], win_m[i]} = {32'h0, 32'h0, 32'h0};
    rstn_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    // Reset contents read back as zero on both pages
    for (int k = 0; k < 2; k++) begin
      setsel(k[0], 4'h0, 3, 1'b0);
      acc(1'b0, k[0], bwsc_pkg::OFF_STRIDE, 32'h0);
      acc(1'b0, k[0], bwsc_pkg::OFF_WINDOW, 32'h0);
    end
    $display("Test reset values done");
    // Random traffic over pages, instances, partitions and offsets
    repeat (150) begin
      s = $random(seed);
      r = $random(seed);
      p = $unsigned($random(seed)) % 10;
      nrw_in = $random(seed);
      setsel(s, {3'h0, r}, p, nrw_in);
      acc(1'b1, s, addrs[$unsigned($random(seed)) % 3], $random(seed));
      acc(1'b0, s, addrs[$unsigned($random(seed)) % 3], 32'h0);
      if (p < 8) rq(s, p, r);
    end
    $display("Test random traffic done");
    // Wrong internal bit with narrowing: error, write dropped
    nrw_in = 1'b1;
    setsel(1'b1, 4'h0, 2, 1'b0);
    acc(1'b1, 1'b1, bwsc_pkg::OFF_STRIDE, 32'h800000aa);
    acc(1'b0, 1'b1, bwsc_pkg::OFF_WINDOW, 32'h0);
    setsel(1'b1, 4'h0, 2, 1'b1);
    acc(1'b0, 1'b1, bwsc_pkg::OFF_STRIDE, 32'h0);
    // Instance beyond the stored pair: dropped, must not alias instance 0
    setsel(1'b0, 4'h2, 1, 1'b1);
    acc(1'b1, 1'b0, bwsc_pkg::OFF_STRIDE, 32'h800000cc);
    acc(1'b0, 1'b0, bwsc_pkg::OFF_STRIDE, 32'h0);
    setsel(1'b0, 4'h0, 1, 1'b1);
    acc(1'b0, 1'b0, bwsc_pkg::OFF_STRIDE, 32'h0);
    $display("Test internal bit error done");
    // Read-only window shows hardware width, then stored value returns
    wwf_in = 1'b0;
    hw_window_in = $random(seed);
    acc(1'b1, 1'b1, bwsc_pkg::OFF_WINDOW, 32'h00123456);
    acc(1'b0, 1'b1, bwsc_pkg::OFF_WINDOW, 32'h0);
    rq(1'b1, 2, 1'b0);
    wwf_in = 1'b1;
    acc(1'b0, 1'b1, bwsc_pkg::OFF_WINDOW, 32'h0);
    $display("Test read-only window done");
    // Missing capabilities make the registers reserved
    ssp_in = 1'b0;
    acc(1'b1, 1'b1, bwsc_pkg::OFF_STRIDE, 32'hffffffff);
    acc(1'b0, 1'b1, bwsc_pkg::OFF_STRIDE, 32'h0);
    ssp_in = 1'b1;
    bwp_in = 1'b0;
    acc(1'b1, 1'b1, bwsc_pkg::OFF_WINDOW, 32'h00ffffff);
    acc(1'b0, 1'b1, bwsc_pkg::OFF_WINDOW, 32'h0);
    bwp_in = 1'b1;
    acc(1'b0, 1'b1, bwsc_pkg::OFF_STRIDE, 32'h0);
    $display("Test absent registers done");
    // Without instance selection the instance field is ignored
    {isp_in, nrw_in} = 2'b00;
    setsel(1'b0, 4'h1, 5, 1'b0);
    acc(1'b1, 1'b0, bwsc_pkg::OFF_STRIDE, 32'h80000077);
    setsel(1'b0, 4'h0, 5, 1'b0);
    acc(1'b0, 1'b0, bwsc_pkg::OFF_STRIDE, 32'h0);
    $display("Test instance select absent done");
    summarize();
  end
endmodule

`default_nettype wire
